// >>> logic/cbt_consts.vh
/*
 Constants of the CAN bit timing and power mode block: register offsets,
 field positions, reset values and mode codes.
 Assumes it is included once per design file by its bare name.
*/
// What this block does
// (RULE_01) Protocol clock comes from the oscillator tick or the bus clock, per select bit.
// (RULE_02) Quantum tick is the protocol clock divided by a programmable prescaler.
// (RULE_03) Each bit is sync segment, phase one, phase two; rate is quanta per bit.
// (RULE_04) Sync segment lasts exactly one quantum; bus edges expected inside it.
// (RULE_05) Phase one is programmable from 4 to 16 quanta.
// (RULE_06) Phase two is programmable from 2 to 8 quanta.
// (RULE_07) Jump width is programmable from 1 to 4 quanta.
// (RULE_08) Each timing field holds length minus one.
// (RULE_09) New transmit bit is driven at the transmit point, the bit start.
// (RULE_10) Bus is sampled at the sample point; triple mode votes three samples.
// (RULE_11) Software must program standard-compliant segment combinations.
// (RULE_12) Listen-only receives frames, sends only recessive, never starts transmitting.
// (RULE_13) Listen-only loops dominant protocol bits back internally, bus stays recessive.
// (RULE_14) Module enable clear stops all controller clocks.
// (RULE_15) Sleep stops internal clocks but keeps register access running.
// (RULE_16) Power-down stops all clocks; no register access.
// (RULE_17) Wake interrupt only in sleep with wake detect and its enable set.
// (RULE_18) CPU running: normal when request and acknowledge clear, sleep when both set.
// (RULE_19) CPU wait with stop-in-wait set enters power-down, else normal or sleep.
// (RULE_20) Leaving wait power-down restarts controllers and returns to normal.
// (RULE_21) In CPU wait with normal mode the block keeps running and interrupting.
// (RULE_22) CPU stop forces power-down regardless of other bits; the code keeps disabled mode instead while the enable bit is clear.
// (RULE_23) Software treats sleep acknowledge as the handshake for its sleep request.
// (RULE_24) Power-down aborts traffic at once and forces transmit pin recessive.
// (RULE_25) Prescaler divides by at least one; quantum counter restarts at sync edges.
// (RULE_26) Clock source select takes effect only in initialization mode.
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (word index)
// ------------------------------------------------------------
`define CBT_ADDR_CTRL      3'h0
`define CBT_ADDR_TIMING    3'h1
`define CBT_ADDR_STATUS    3'h2

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CBT_CTL_INIT_REQ   0
`define CBT_CTL_SLEEP_REQ  1
`define CBT_CTL_STOP_WAIT  2
`define CBT_CTL_WAKE_DET   3
`define CBT_CTL_WAKE_IE    4
`define CBT_CTL_LISTEN     5
`define CBT_CTL_CLK_SEL    6
`define CBT_CTL_ENABLE     7
`define CBT_CTL_RESET      8'h01

// ------------------------------------------------------------
// Timing register fields
// ------------------------------------------------------------
`define CBT_TIM_PRESC_LO   0
`define CBT_TIM_PRESC_HI   5
`define CBT_TIM_SJW_LO     6
`define CBT_TIM_SJW_HI     7
`define CBT_TIM_PH1_LO     8
`define CBT_TIM_PH1_HI     11
`define CBT_TIM_PH2_LO     12
`define CBT_TIM_PH2_HI     14
`define CBT_TIM_TRIPLE     15
`define CBT_TIM_RESET      16'h2300

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define CBT_ST_INIT_ACK    0
`define CBT_ST_SLEEP_ACK   1
`define CBT_ST_WAKE_FLAG   2
`define CBT_ST_RX_BIT      3
`define CBT_ST_MODE_LO     4
`define CBT_ST_MODE_HI     8

// ------------------------------------------------------------
// Operating modes, one-hot
// ------------------------------------------------------------
`define CBT_MODE_NORMAL    5'h01
`define CBT_MODE_SLEEP     5'h02
`define CBT_MODE_PDOWN     5'h04
`define CBT_MODE_DISABLED  5'h08
`define CBT_MODE_INIT      5'h10

// ------------------------------------------------------------
// Bit segments, one-hot
// ------------------------------------------------------------
`define CBT_SEG_SYNC       3'h1
`define CBT_SEG_PH1        3'h2
`define CBT_SEG_PH2        3'h4

`endif

// >>> logic/cbt_bit_timing.v
/*
 CAN bit timing, clock source, listen-only and power mode control with an
 Avalon-MM register slave.
 Assumes one clock ref_clk; the oscillator arrives as a one-cycle tick,
 the protocol layer sits on the same clock, rx_pin comes from the bus.
*/
`timescale 1ns/1ps
`include "cbt_consts.vh"

module cbt_bit_timing (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire [2:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        osc_tick,
	input  wire        cpu_wait,
	input  wire        cpu_stop,
	input  wire        rx_pin,
	output reg         transmit_pin,
	input  wire        proto_tx_bit,
	input  wire        proto_frame_active,
	input  wire        proto_idle,
	output reg         proto_rx_bit,
	output reg         sample_point,
	output reg         tx_point,
	output wire        tx_start_allowed,
	output wire        proto_clk_run,
	output reg         abort_pulse,
	output wire        wakeup_irq,
	output wire [4:0]  mode
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg  [7:0]  ctrl_reg;
	reg  [15:0] timing_reg;
	reg         init_ack_reg;
	reg         sleep_ack_reg;
	reg         wake_flag_reg;
	reg         enable_locked_reg;
	reg         clk_sel_reg;
	reg         ack_reg;
	reg  [4:0]  mode_reg;
	reg  [4:0]  mode_next;
	reg  [5:0]  presc_cnt_reg;
	reg  [2:0]  seg_reg;
	reg  [4:0]  tq_cnt_reg;
	reg  [4:0]  ext_reg;
	reg         edge_pend_reg;
	reg  [2:0]  rx_hist_reg;
	reg         rx_s1_reg;
	reg         rx_s2_reg;
	reg         rx_s3_reg;
	reg         rx_filt_reg;
	reg         rx_bit_reg;
	reg         tx_bit_reg;

	wire        in_pdown;
	wire        in_sleep;
	wire        in_init;
	wire        run;
	wire        proto_tick;
	wire        tq_tick;
	wire        rx_edge;
	wire        wr_ok;
	wire [4:0]  ph1_len;
	wire [4:0]  ph2_len;
	wire [4:0]  sjw_len;
	wire [4:0]  late_err;
	wire [4:0]  early_err;
	wire        vote;
	wire        listen;
	wire        sync_edge;
	wire        hard_sync;
	wire        ph2_restart;
	wire [4:0]  ph2_skip;
	wire        force_recessive;

	assign listen   = ctrl_reg[`CBT_CTL_LISTEN];
	assign ph1_len  = {1'b0, timing_reg[`CBT_TIM_PH1_HI:`CBT_TIM_PH1_LO]} + 5'h01; // RULE_05 RULE_08
	assign ph2_len  = {2'b00, timing_reg[`CBT_TIM_PH2_HI:`CBT_TIM_PH2_LO]} + 5'h01; // RULE_06 RULE_08
	assign sjw_len  = {3'b000, timing_reg[`CBT_TIM_SJW_HI:`CBT_TIM_SJW_LO]} + 5'h01; // RULE_07 RULE_08

	// ------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------
	// Disable outranks all; power-down outranks init and sleep
	always @* begin
		if (!ctrl_reg[`CBT_CTL_ENABLE])
			mode_next = `CBT_MODE_DISABLED; // RULE_14
		else if (cpu_stop)
			mode_next = `CBT_MODE_PDOWN; // RULE_22
		else if (cpu_wait && ctrl_reg[`CBT_CTL_STOP_WAIT])
			mode_next = `CBT_MODE_PDOWN; // RULE_19
		else if (init_ack_reg)
			mode_next = `CBT_MODE_INIT;
		else if (ctrl_reg[`CBT_CTL_SLEEP_REQ] && sleep_ack_reg)
			mode_next = `CBT_MODE_SLEEP; // RULE_18 RULE_19
		else
			mode_next = `CBT_MODE_NORMAL; // RULE_18 RULE_21
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= `CBT_MODE_DISABLED;
		else
			mode_reg <= mode_next;
	end

	assign mode     = mode_reg;
	assign in_pdown = (mode_reg == `CBT_MODE_PDOWN);
	assign in_sleep = (mode_reg == `CBT_MODE_SLEEP);
	assign in_init  = (mode_reg == `CBT_MODE_INIT);
	assign run      = (mode_reg == `CBT_MODE_NORMAL); // RULE_14 RULE_15 RULE_16
	assign proto_clk_run    = run;
	assign tx_start_allowed = run && !listen; // RULE_12
	assign wakeup_irq = wake_flag_reg && ctrl_reg[`CBT_CTL_WAKE_IE]; // RULE_17

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	// One wait state per access; requests wait out power-down
	assign avs_waitrequest = !ack_reg;
	assign wr_ok = avs_write && ack_reg;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg      <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg && !in_pdown; // RULE_16
			if (avs_read && !ack_reg) begin
				case (avs_address)
					`CBT_ADDR_CTRL:   avs_readdata <= {24'h000000, ctrl_reg};
					`CBT_ADDR_TIMING: avs_readdata <= {16'h0000, timing_reg};
					`CBT_ADDR_STATUS: avs_readdata <= {23'h000000, mode_reg, rx_bit_reg,
						wake_flag_reg, sleep_ack_reg, init_ack_reg};
					default:          avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Control and handshakes
	// ------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg          <= `CBT_CTL_RESET;
			timing_reg        <= `CBT_TIM_RESET;
			init_ack_reg      <= 1'b0;
			sleep_ack_reg     <= 1'b0;
			wake_flag_reg     <= 1'b0;
			enable_locked_reg <= 1'b0;
			clk_sel_reg       <= 1'b0;
		end else begin
			init_ack_reg <= ctrl_reg[`CBT_CTL_INIT_REQ] && ctrl_reg[`CBT_CTL_ENABLE];
			if (in_init)
				clk_sel_reg <= ctrl_reg[`CBT_CTL_CLK_SEL]; // RULE_26
			if (ctrl_reg[`CBT_CTL_SLEEP_REQ] && !sleep_ack_reg && run && proto_idle)
				sleep_ack_reg <= 1'b1;
			// Power-down drops the sleep handshake so leaving it lands in normal
			if (in_pdown) begin
				ctrl_reg[`CBT_CTL_SLEEP_REQ] <= 1'b0; // RULE_20
				sleep_ack_reg <= 1'b0;
			end
			if (wr_ok && avs_address == `CBT_ADDR_CTRL) begin
				ctrl_reg[`CBT_CTL_INIT_REQ]  <= avs_writedata[`CBT_CTL_INIT_REQ];
				ctrl_reg[`CBT_CTL_STOP_WAIT] <= avs_writedata[`CBT_CTL_STOP_WAIT];
				ctrl_reg[`CBT_CTL_WAKE_DET]  <= avs_writedata[`CBT_CTL_WAKE_DET];
				ctrl_reg[`CBT_CTL_WAKE_IE]   <= avs_writedata[`CBT_CTL_WAKE_IE];
				if (!ctrl_reg[`CBT_CTL_SLEEP_REQ] || sleep_ack_reg) begin
					ctrl_reg[`CBT_CTL_SLEEP_REQ] <= avs_writedata[`CBT_CTL_SLEEP_REQ];
					if (!avs_writedata[`CBT_CTL_SLEEP_REQ])
						sleep_ack_reg <= 1'b0;
				end
				if (init_ack_reg) begin
					ctrl_reg[`CBT_CTL_LISTEN]  <= avs_writedata[`CBT_CTL_LISTEN];
					ctrl_reg[`CBT_CTL_CLK_SEL] <= avs_writedata[`CBT_CTL_CLK_SEL];
				end
				// Enable is writable once, guarding against an accidental switch-off
				if (!enable_locked_reg) begin
					ctrl_reg[`CBT_CTL_ENABLE] <= avs_writedata[`CBT_CTL_ENABLE];
					enable_locked_reg <= 1'b1;
				end
			end
			if (wr_ok && avs_address == `CBT_ADDR_TIMING && init_ack_reg)
				timing_reg <= avs_writedata[15:0];
			if (wr_ok && avs_address == `CBT_ADDR_STATUS && avs_writedata[`CBT_ST_WAKE_FLAG])
				wake_flag_reg <= 1'b0;
			// Wake-up: set wins over a simultaneous software clear
			if (in_sleep && ctrl_reg[`CBT_CTL_WAKE_DET] && rx_edge) begin
				wake_flag_reg <= 1'b1; // RULE_17
				ctrl_reg[`CBT_CTL_SLEEP_REQ] <= 1'b0;
				sleep_ack_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_reg   <= 1'b1;
			rx_s2_reg   <= 1'b1;
			rx_s3_reg   <= 1'b1;
			rx_filt_reg <= 1'b1;
		end else begin
			rx_s1_reg <= rx_pin;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_filt_reg <= rx_s3_reg;
		end
	end

	// Falling edge once the late stages agree; reset level is recessive
	assign rx_edge = rx_filt_reg && (rx_s2_reg == rx_s3_reg) && !rx_s3_reg;

	// ------------------------------------------------------------
	// Protocol clock and prescaler
	// ------------------------------------------------------------
	// Bus clock ticks every cycle; the oscillator arrives as a tick
	assign proto_tick = clk_sel_reg ? 1'b1 : osc_tick; // RULE_01
	assign tq_tick = run && proto_tick &&
		(presc_cnt_reg == timing_reg[`CBT_TIM_PRESC_HI:`CBT_TIM_PRESC_LO]); // RULE_02 RULE_25

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			presc_cnt_reg <= 6'h00;
		else if (!run)
			presc_cnt_reg <= 6'h00; // RULE_14 RULE_20
		else if (tq_tick)
			presc_cnt_reg <= 6'h00;
		else if (proto_tick)
			presc_cnt_reg <= presc_cnt_reg + 6'h01;
	end

	// ------------------------------------------------------------
	// Resynchronisation decisions
	// ------------------------------------------------------------
	// Phase error clipped to the jump width on both sides, so one
	// edge inside a frame never moves the bit by more than the programmed limit
	assign late_err    = (tq_cnt_reg + 5'h01 < sjw_len) ? tq_cnt_reg + 5'h01 : sjw_len; // RULE_07
	assign early_err   = ph2_len - tq_cnt_reg - 5'h01;
	assign sync_edge   = edge_pend_reg || rx_edge;
	assign hard_sync   = sync_edge && !proto_frame_active; // RULE_25
	assign ph2_restart = sync_edge && (early_err <= sjw_len); // RULE_07 RULE_25
	assign ph2_skip    = tq_cnt_reg + 5'h01 + sjw_len; // RULE_07

	// ------------------------------------------------------------
	// Bit segment engine
	// ------------------------------------------------------------
	assign vote = (rx_hist_reg[0] & rx_hist_reg[1]) | (rx_hist_reg[0] & rx_filt_reg) |
		(rx_hist_reg[1] & rx_filt_reg);

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_reg       <= `CBT_SEG_SYNC;
			tq_cnt_reg    <= 5'h00;
			ext_reg       <= 5'h00;
			edge_pend_reg <= 1'b0;
			rx_hist_reg   <= 3'h7;
			rx_bit_reg    <= 1'b1;
			sample_point  <= 1'b0;
			tx_point      <= 1'b0;
		end else begin
			sample_point <= 1'b0;
			tx_point     <= 1'b0;
			if (!run) begin
				seg_reg       <= `CBT_SEG_SYNC; // RULE_24 RULE_20
				tq_cnt_reg    <= 5'h00;
				ext_reg       <= 5'h00;
				edge_pend_reg <= 1'b0;
			end else begin
				if (rx_edge)
					edge_pend_reg <= 1'b1;
				if (tq_tick) begin
					edge_pend_reg <= 1'b0;
					rx_hist_reg   <= {rx_hist_reg[1:0], rx_filt_reg};
					if (hard_sync) begin
						seg_reg    <= `CBT_SEG_PH1; // RULE_25
						tq_cnt_reg <= 5'h00;
						ext_reg    <= 5'h00;
						tx_point   <= 1'b1;
					end else begin
						case (seg_reg)
							`CBT_SEG_SYNC: begin
								seg_reg    <= `CBT_SEG_PH1; // RULE_04
								tq_cnt_reg <= 5'h00;
								ext_reg    <= 5'h00;
							end
							`CBT_SEG_PH1: begin
								if (sync_edge && ext_reg == 5'h00)
									ext_reg <= late_err; // RULE_25
								if (tq_cnt_reg + 5'h01 >= ph1_len + ext_reg) begin
									seg_reg      <= `CBT_SEG_PH2; // RULE_03
									tq_cnt_reg   <= 5'h00;
									sample_point <= 1'b1; // RULE_10
									rx_bit_reg   <= timing_reg[`CBT_TIM_TRIPLE] ? vote : rx_filt_reg;
								end else begin
									tq_cnt_reg <= tq_cnt_reg + 5'h01;
								end
							end
							`CBT_SEG_PH2: begin
								if (ph2_restart) begin
									seg_reg    <= `CBT_SEG_PH1; // RULE_25
									tq_cnt_reg <= 5'h00;
									ext_reg    <= 5'h00;
									tx_point   <= 1'b1;
								end else if (tq_cnt_reg + 5'h01 >= ph2_len) begin
									seg_reg  <= `CBT_SEG_SYNC; // RULE_03
									tx_point <= 1'b1; // RULE_09
								end else if (sync_edge) begin
									// Early edge beyond the jump width: shorten by the width only
									tq_cnt_reg <= ph2_skip; // RULE_07
								end else begin
									tq_cnt_reg <= tq_cnt_reg + 5'h01;
								end
							end
							default: begin
								seg_reg    <= `CBT_SEG_SYNC;
								tq_cnt_reg <= 5'h00;
							end
						endcase
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit pin and loop-back
	// ------------------------------------------------------------
	// Pin goes recessive on the very edge that leaves normal mode
	assign force_recessive = !run || listen || (mode_next != `CBT_MODE_NORMAL); // RULE_12 RULE_24

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_pin <= 1'b1;
			tx_bit_reg   <= 1'b1;
			proto_rx_bit <= 1'b1;
			abort_pulse  <= 1'b0;
		end else begin
			abort_pulse <= (mode_next == `CBT_MODE_PDOWN || mode_next == `CBT_MODE_INIT) &&
				!(in_pdown || in_init); // RULE_24
			if (force_recessive)
				transmit_pin <= 1'b1; // RULE_12 RULE_24
			else if (tx_point)
				transmit_pin <= tx_bit_reg; // RULE_09
			if (tx_point)
				tx_bit_reg <= proto_tx_bit;
			if (!run)
				tx_bit_reg <= 1'b1;
			proto_rx_bit <= listen ? (rx_bit_reg & tx_bit_reg) : rx_bit_reg; // RULE_13
		end
	end

endmodule

// >>> verif/cbt_bus_node.sv
/*
 Far-side model: the CAN bus line with its pull-up and one other node.
 Assumes the device transmit pin and the bench's dominant request as inputs.
*/
`timescale 1ns/1ps
module cbt_bus_node (
	input  wire tx_line,
	input  wire dom_req,
	output wire rx_line
);
	// --------------------------------
	// Wired-AND bus, recessive when released
	// --------------------------------
	assign rx_line = tx_line & ~dom_req;
endmodule

// >>> verif/cbt_bit_timing_chk.sv
/*
 Assertion checker for the CAN bit timing block, bound to its ports.
 Assumes one clock ref_clk and the active-low asynchronous reset rst_n.
*/
`timescale 1ns/1ps
module cbt_bit_timing_chk (
	input wire       ref_clk,
	input wire       rst_n,
	input wire       avs_read,
	input wire       avs_write,
	input wire       avs_waitrequest,
	input wire       cpu_stop,
	input wire       transmit_pin,
	input wire       sample_point,
	input wire       tx_point,
	input wire       tx_start_allowed,
	input wire       proto_clk_run,
	input wire       abort_pulse,
	input wire       wakeup_irq,
	input wire [4:0] mode
);
	// --------------------------------
	// Sequences
	// --------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_enter_pd;
		mode != 5'h04 ##1 mode == 5'h04;
	endsequence
	sequence s_request;
		!(avs_read || avs_write) ##1 (avs_read || avs_write) && mode != 5'h04;
	endsequence
	sequence s_stop_held;
		cpu_stop [*3];
	endsequence
	// --------------------------------
	// Assertions
	// --------------------------------
	chk_bus_one_wait: assert property (s_request |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_pd_no_access: assert property (mode == 5'h04 && $past(mode) == 5'h04 |-> avs_waitrequest)
		else $error("access in power-down");
	chk_clk_run_mode: assert property (proto_clk_run == (mode == 5'h01))
		else $error("clock run outside normal");
	chk_pd_recessive: assert property (mode == 5'h04 |-> transmit_pin)
		else $error("dominant in power-down");
	chk_abort_on_pd: assert property (s_enter_pd |-> ##[0:1] abort_pulse)
		else $error("no abort on power-down");
	chk_stop_to_pd: assert property (s_stop_held |-> mode == 5'h04 || mode == 5'h08)
		else $error("stop not power-down");
	chk_listen_recessive: assert property (mode == 5'h01 && !tx_start_allowed |-> transmit_pin)
		else $error("dominant in listen-only");
	chk_tx_pulse_one: assert property (tx_point |=> !tx_point)
		else $error("transmit point too long");
	chk_sample_pulse_one: assert property (sample_point |=> !sample_point)
		else $error("sample point too long");
	chk_irq_from_sleep: assert property ($rose(wakeup_irq) |-> $past(mode) == 5'h02)
		else $error("wake irq outside sleep");
endmodule

bind cbt_bit_timing cbt_bit_timing_chk u_cbt_bit_timing_chk (.ref_clk, .rst_n, .avs_read, .avs_write,
	.avs_waitrequest, .cpu_stop, .transmit_pin, .sample_point, .tx_point, .tx_start_allowed,
	.proto_clk_run, .abort_pulse, .wakeup_irq, .mode);

// >>> verif/test_cbt_bit_timing.sv
/*
 Self-checking testbench of the CAN bit timing and power mode block.
 Assumes the bus node model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module test_cbt_bit_timing;
	reg         ref_clk, rst_n, avs_read, avs_write, osc_tick, cpu_wait, cpu_stop, proto_tx_bit, node_dom;
	reg         frame_act;
	reg  [2:0]  avs_address;
	reg  [31:0] avs_writedata, rd;
	reg  [1:0]  osc_cnt;
	wire [31:0] avs_readdata;
	wire [4:0]  mode;
	wire        avs_waitrequest, rx_pin, transmit_pin, proto_rx_bit, sample_point, tx_point;
	wire        tx_start_allowed, proto_clk_run, abort_pulse, wakeup_irq;
	integer     error_cnt, comparisons, n;

	cbt_bit_timing u_cbt_bit_timing (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .osc_tick, .cpu_wait, .cpu_stop, .rx_pin, .transmit_pin,
		.proto_tx_bit, .proto_frame_active(frame_act), .proto_idle(1'b1), .proto_rx_bit, .sample_point,
		.tx_point, .tx_start_allowed, .proto_clk_run, .abort_pulse, .wakeup_irq, .mode);
	cbt_bus_node u_cbt_bus_node (.tx_line(transmit_pin), .dom_req(node_dom), .rx_line(rx_pin));

	// --------------------------------
	// Clock, oscillator tick every fourth cycle
	// --------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			osc_cnt  <= 2'h0;
			osc_tick <= 1'b0;
		end else begin
			osc_cnt  <= osc_cnt + 2'h1;
			osc_tick <= (osc_cnt == 2'h3);
		end
	end

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
			if (error_cnt == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task bus(input w, input [2:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge ref_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			k = 0;
			do begin
				@(posedge ref_clk);
				k = k + 1;
			end while (avs_waitrequest !== 1'b0 && k < 100);
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			chk(k < 100, 1);
		end
	endtask
	task bit_len(output integer len);
		integer k;
		begin
			k = 0;
			do begin
				@(posedge ref_clk);
				k = k + 1;
			end while (tx_point !== 1'b1 && k < 300);
			len = 0;
			do begin
				@(posedge ref_clk);
				len = len + 1;
			end while (tx_point !== 1'b1 && len < 300);
		end
	endtask
	task cfg(input [7:0] c, input [15:0] t);
		begin
			bus(1'b1, 3'h0, {24'h0, c | 8'h01});
			bus(1'b1, 3'h1, {16'h0, t});
			bus(1'b1, 3'h0, {24'h0, c});
			repeat (4) @(posedge ref_clk);
		end
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task t_reset;
		begin
			chk(mode, 5'h08);
			chk(proto_clk_run, 1'b0);
			chk(transmit_pin, 1'b1);
			bus(1'b0, 3'h1, 32'h0);
			chk(rd, 32'h2300);
			bus(1'b0, 3'h5, 32'h0);
			chk(rd, 32'h0);
		end
	endtask
	task t_bits(input [7:0] c, input [15:0] t);
		integer e;
		begin
			cfg(c, t);
			e = (3 + t[11:8] + t[14:12]) * (t[5:0] + 1) * (c[6] ? 1 : 4);
			bit_len(n);
			chk(n, e);
			chk(mode, 5'h01);
		end
	endtask
	task t_tx;
		begin
			proto_tx_bit <= 1'b0;
			repeat (3) bit_len(n);
			chk(transmit_pin, 1'b0);
			chk(tx_start_allowed, 1'b1);
			bit_len(n);
			chk(proto_rx_bit, 1'b0);
			proto_tx_bit <= 1'b1;
			repeat (3) bit_len(n);
			chk(transmit_pin, 1'b1);
		end
	endtask
	task t_listen;
		begin
			cfg(8'hE0, 16'h2300);
			proto_tx_bit <= 1'b0;
			repeat (4) bit_len(n);
			chk(transmit_pin, 1'b1);
			chk(tx_start_allowed, 1'b0);
			chk(proto_rx_bit, 1'b0);
			chk(rx_pin, 1'b1);
			cfg(8'hC0, 16'h2300);
		end
	endtask
	task t_power;
		begin
			cpu_wait <= 1'b1;
			repeat (3) bit_len(n);
			chk(mode, 5'h01);
			chk(transmit_pin, 1'b0);
			cpu_wait <= 1'b0;
			bus(1'b1, 3'h0, 32'hC4);
			cpu_wait <= 1'b1;
			repeat (4) @(posedge ref_clk);
			chk(mode, 5'h04);
			chk(transmit_pin, 1'b1);
			avs_address <= 3'h2;
			avs_read <= 1'b1;
			repeat (6) @(posedge ref_clk);
			chk(avs_waitrequest, 1'b1);
			cpu_wait <= 1'b0;
			n = 0;
			do begin
				@(posedge ref_clk);
				n = n + 1;
			end while (avs_waitrequest !== 1'b0 && n < 50);
			chk(n < 50, 1);
			chk(avs_readdata[8:4], 5'h01);
			avs_read <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(mode, 5'h01);
			bus(1'b1, 3'h0, 32'hC0);
			cpu_stop <= 1'b1;
			repeat (4) @(posedge ref_clk);
			chk(mode, 5'h04);
			cpu_stop <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk(mode, 5'h01);
			proto_tx_bit <= 1'b1;
		end
	endtask
	task t_sleep;
		begin
			bus(1'b1, 3'h0, 32'hDA);
			repeat (8) @(posedge ref_clk);
			bus(1'b0, 3'h2, 32'h0);
			chk(rd[1], 1'b1);
			chk(rd[8:4], 5'h02);
			chk(proto_clk_run, 1'b0);
			chk(wakeup_irq, 1'b0);
			node_dom <= 1'b1;
			repeat (10) @(posedge ref_clk);
			node_dom <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk(wakeup_irq, 1'b1);
			chk(mode, 5'h01);
			bus(1'b1, 3'h2, 32'h4);
			repeat (2) @(posedge ref_clk);
			chk(wakeup_irq, 1'b0);
		end
	endtask
	task t_soft;
		begin
			frame_act <= 1'b1;
			bit_len(n);
			node_dom <= 1'b1;
			n = 0;
			do begin
				@(posedge ref_clk);
				n = n + 1;
			end while (tx_point !== 1'b1 && n < 300);
			chk(n >= 7 && n <= 9, 1);
			node_dom <= 1'b0;
			frame_act <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
	endtask

	// --------------------------------
	// Main sequence and watchdog
	// --------------------------------
	initial begin
		{rst_n, avs_read, avs_write, cpu_wait, cpu_stop, node_dom, frame_act} = 7'h00;
		{avs_address, avs_writedata} = 35'h0;
		proto_tx_bit = 1'b1;
		error_cnt = 0;
		comparisons = 0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_bits(8'hC0, 16'h2300);
		t_bits(8'hC0, 16'h1300);
		t_bits(8'hC0, 16'h7FC0);
		t_bits(8'hC0, 16'h7FC1);
		t_bits(8'hC0, 16'hA300);
		t_bits(8'h80, 16'h2300);
		t_bits(8'hC0, 16'h2300);
		t_tx;
		t_listen;
		proto_tx_bit <= 1'b0;
		t_power;
		t_sleep;
		t_soft;
		stop_test;
	end
	initial begin
		#1000000;
		error_cnt = error_cnt + 1;
		stop_test;
	end
endmodule
